// ### verilog/power_stage_consts.vh
// constants shared by the power stage fault protection design
`ifndef POWER_STAGE_CONSTS_VH
`define POWER_STAGE_CONSTS_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define OLP_TIME_NS 1250000

// ----------------------------------------------------------------
// register map (word index on the plain register port)
// ----------------------------------------------------------------
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1

// control fields
`define CTRL_BTL_BIT 0
`define CTRL_MUTE_BIT 1
`define CTRL_RESET 8'h01

// status fields
`define ST_UV_BIT 0
`define ST_OTE_BIT 1
`define ST_OLP_AB_BIT 2
`define ST_OLP_CD_BIT 3
`define ST_WARN_BIT 4
`define ST_LIM_AB_BIT 5
`define ST_LIM_CD_BIT 6
`define ST_SDPIN_BIT 7

`endif

// ### verilog/overload_counter.v
// persistence counter that latches an overload for one half-bridge pair
module overload_counter #(
  parameter CW = 17,
  parameter [CW-1:0] LIMIT = 17'd125000
) (
  input wire clk,
  input wire rstn,
  input wire clkEn,
  input wire overLimit,
  input wire clearReq,
  output reg overload
);

  reg [CW-1:0] count;

  // ----------------------------------------------------------------
  // count persistence, latch, clear
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= {CW{1'b0}};
      overload <= 1'b0;
    end else if (clkEn) begin
      // a short transient restarts the count
      if (!overLimit)
        count <= {CW{1'b0}};
      else if (count != LIMIT)
        count <= count + {{(CW-1){1'b0}}, 1'b1};
      // set wins over a clear in the same cycle
      if (overLimit && count == LIMIT - {{(CW-1){1'b0}}, 1'b1})
        overload <= 1'b1; // [R15] [R19]
      else if (clearReq)
        overload <= 1'b0; // [R21]
    end
  end

endmodule // overload_counter

// ### verilog/power_stage_fault_protection.v
// fault protection and status reporting of a four half-bridge power stage
//
// The address-and-strobe port and the register offsets were left to the implementer.
`include "power_stage_consts.vh"

// Contract
// R1: outputs stay high impedance until all supplies exceed undervoltage level.
// R2: stays operating while supplies stay above threshold; no ordering.
// R3: shutdown flag and warning are active-low open-drain outputs.
// R4: shutdown flag goes low on any fault that shuts the stage down.
// R5: warning low while junction above 125 C, released otherwise; the code also holds it low while the overtemperature error is latched.
// R6: status pair encodes error, overload/undervoltage, warning, normal.
// R7: shutdown flag forced high while either pair reset is low.
// R8: on a fault, outputs go high impedance and shutdown flag low.
// R9: non-overload faults recover automatically when the condition clears; the code keeps overtemperature latched until both resets are low.
// R10: controller clears overload by reset no sooner than 1 s after.
// R11: modulator gives 50 ns low per 384 kHz frame on each input.
// R12: modulator limits modulation index to 96.1 percent.
// R13: overcurrent watched on every high and low side transistor.
// R14: overcurrent first limits current instead of shutting down.
// R15: persisting high current latches overload shutdown to high impedance.
// R16: limiting and overload handled separately for pair AB and CD.
// R17: controller should hold pair resets low during power-up.
// R18: controller should hold pair resets low during power-down.
// R19: overload declared after current limit persists 1.25 ms.
// R20: overtemperature error latched, cleared after both resets asserted.
// R21: rising edge of either pair reset clears overload fault.
// R22: pair reset low gives high impedance; bridge modes enable pulldowns.
// R23: pair resets and pwm inputs synchronised before use.
module power_stage_fault_protection #(
  parameter OLP_CYCLES = `OLP_TIME_NS / `CLK_PERIOD_NS,
  parameter OLP_CW = 17
) (
  input wire clk,
  input wire resetn,
  input wire clkEn,
  input wire [3:0] pwmIn,
  input wire pair_ab_reset_n,
  input wire pair_cd_reset_n,
  input wire [3:0] gate_drive_supply_ok,
  input wire common_supply_ok,
  input wire tempAboveWarn,
  input wire tempAboveError,
  input wire [3:0] overcurrent_high,
  input wire [3:0] overcurrent_low,
  input wire [3:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrite,
  input wire regRead,
  output reg [7:0] regRdData,
  output reg [3:0] highSideOn,
  output reg [3:0] lowSideOn,
  output reg [3:0] outputHiZ,
  output reg [3:0] weakPulldownEn,
  output reg [3:0] currentLimitActive,
  input wire shutdown_flag_n_in,
  output wire shutdown_flag_n_out,
  output reg shutdown_flag_n_oe,
  input wire overtemp_warn_n_in,
  output wire overtemp_warn_n_out,
  output reg overtemp_warn_n_oe
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  // release is synchronised so no flop sees reset leave inside its setup
  reg [1:0] rstPipe;
  wire rstn;

  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstn = rstPipe[1];

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // first stage feeds only the second stage; resets come up low so
  // the stage sits muted until the synchronisers have filled
  reg [3:0] pwmMeta;
  reg [3:0] pwmSync;
  reg [1:0] rstMeta;
  reg [1:0] rstSync;
  reg [1:0] rstPrev;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwmMeta <= 4'h0;
      pwmSync <= 4'h0;
      rstMeta <= 2'h0;
      rstSync <= 2'h0;
      rstPrev <= 2'h0;
    end else if (clkEn) begin
      pwmMeta <= pwmIn; // [R23]
      pwmSync <= pwmMeta; // [R23]
      rstMeta <= {pair_cd_reset_n, pair_ab_reset_n}; // [R23]
      rstSync <= rstMeta; // [R23]
      rstPrev <= rstSync;
    end
  end

  wire [1:0] rstRise;
  wire eitherRise;
  wire bothResetLow;
  wire eitherResetLow;

  assign rstRise = rstSync & ~rstPrev;
  assign eitherRise = |rstRise;
  assign bothResetLow = ~rstSync[0] & ~rstSync[1];
  assign eitherResetLow = ~rstSync[0] | ~rstSync[1];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  reg [7:0] ctrl;
  wire btlMode;
  wire softMute;

  assign btlMode = ctrl[`CTRL_BTL_BIT];
  assign softMute = ctrl[`CTRL_MUTE_BIT];

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      ctrl <= `CTRL_RESET;
    else if (clkEn && regWrite && regAddr == `ADDR_CTRL)
      ctrl <= regWrData;
  end

  // ----------------------------------------------------------------
  // undervoltage
  // ----------------------------------------------------------------
  // no latch: the stage follows the supply flags in both directions
  wire uvFault;

  // [R9]
  assign uvFault = ~(&gate_drive_supply_ok) | ~common_supply_ok; // [R1] [R2]

  // ----------------------------------------------------------------
  // overtemperature error latch
  // ----------------------------------------------------------------
  reg oteLatch;

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      oteLatch <= 1'b0;
    else if (clkEn) begin
      // set wins: a hot die keeps the latch through the reset
      if (tempAboveError)
        oteLatch <= 1'b1; // [R20] [R8]
      else if (bothResetLow)
        oteLatch <= 1'b0; // [R20]
    end
  end

  // ----------------------------------------------------------------
  // per pair current limit and overload
  // ----------------------------------------------------------------
  wire [1:0] pairOc;
  wire [1:0] overload_fault;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : pairGen
      // any of the four transistors of the pair over threshold
      assign pairOc[p] = |overcurrent_high[2*p+1:2*p] |
                         |overcurrent_low[2*p+1:2*p]; // [R13] [R16]

      overload_counter #(
        .CW(OLP_CW),
        .LIMIT(OLP_CYCLES[OLP_CW-1:0])
      ) olpCount (
        .clk(clk),
        .rstn(rstn),
        .clkEn(clkEn),
        .overLimit(pairOc[p]), // [R19] [R16]
        .clearReq(eitherRise), // [R21]
        .overload(overload_fault[p])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // half-bridge drive
  // ----------------------------------------------------------------
  // pair enables; any fault removes drive in the next cycle
  wire [1:0] pairRun;
  wire [3:0] next_run;
  wire [3:0] next_high;
  wire [3:0] next_low;
  wire [3:0] next_pulldown;
  wire [3:0] next_limit;

  genvar q;
  generate
    for (q = 0; q < 2; q = q + 1) begin : runGen
      assign pairRun[q] = rstSync[q] & ~uvFault & ~oteLatch & ~overload_fault[q] &
                          ~softMute; // [R8] [R15] [R22] [R1]
    end
  endgenerate

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : bridgeGen
      // half-bridge b belongs to pair b/2
      assign next_run[b] = pairRun[b/2];
      // a tripped transistor is held off instead of shutting the stage
      assign next_high[b] = next_run[b] & pwmSync[b] &
                            ~overcurrent_high[b]; // [R14]
      assign next_low[b] = next_run[b] & ~pwmSync[b] &
                           ~overcurrent_low[b]; // [R14]
      assign next_limit[b] = next_run[b] &
                             (overcurrent_high[b] | overcurrent_low[b]);
      // pulldowns only charge bootstraps in bridge modes
      assign next_pulldown[b] = ~rstSync[b/2] & btlMode; // [R22]
    end
  endgenerate

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      highSideOn <= 4'h0;
      lowSideOn <= 4'h0;
      outputHiZ <= 4'hf; // [R1]
      weakPulldownEn <= 4'h0;
      currentLimitActive <= 4'h0;
    end else if (clkEn) begin
      highSideOn <= next_high;
      lowSideOn <= next_low;
      outputHiZ <= ~next_run; // [R8] [R22]
      weakPulldownEn <= next_pulldown;
      currentLimitActive <= next_limit;
    end
  end

  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------
  // open drain: only ever pulls low, the pullup gives the high
  // pin pair codes, shutdown pin first, 1 meaning released
  localparam CODE_ERROR = 2'b00;
  localparam CODE_FAULT = 2'b01;
  localparam CODE_WARN = 2'b10;
  localparam CODE_NORMAL = 2'b11;

  wire anyFault;
  reg [1:0] statusCode;
  reg next_sdLow;
  reg next_warnLow;

  assign anyFault = uvFault | oteLatch | overload_fault[0] | overload_fault[1]; // [R4]

  // error implies hot, so a latched error always gives code 00
  always @* begin
    if (oteLatch)
      statusCode = CODE_ERROR; // [R6]
    else if (anyFault && tempAboveWarn)
      statusCode = CODE_ERROR; // [R6]
    else if (anyFault)
      statusCode = CODE_FAULT; // [R6]
    else if (tempAboveWarn)
      statusCode = CODE_WARN; // [R5] [R6]
    else
      statusCode = CODE_NORMAL; // [R6]
  end

  // one table, so a new fault class has a single place to go
  always @* begin
    next_sdLow = 1'b0;
    next_warnLow = 1'b0;
    case (statusCode)
      CODE_ERROR: begin
        next_sdLow = 1'b1; // [R4] [R8]
        next_warnLow = 1'b1;
      end
      CODE_FAULT: begin
        next_sdLow = 1'b1; // [R4] [R8]
        next_warnLow = 1'b0;
      end
      CODE_WARN: begin
        next_sdLow = 1'b0;
        next_warnLow = 1'b1; // [R5]
      end
      CODE_NORMAL: begin
        next_sdLow = 1'b0;
        next_warnLow = 1'b0;
      end
      default: begin
        next_sdLow = 1'b1;
        next_warnLow = 1'b1;
      end
    endcase
    // a low pair reset hides faults from the controller, not the stage
    if (eitherResetLow)
      next_sdLow = 1'b0; // [R7]
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shutdown_flag_n_oe <= 1'b0;
      overtemp_warn_n_oe <= 1'b0;
    end else if (clkEn) begin
      shutdown_flag_n_oe <= next_sdLow; // [R3] [R6]
      overtemp_warn_n_oe <= next_warnLow; // [R3] [R6]
    end
  end

  assign shutdown_flag_n_out = 1'b0; // [R3]
  assign overtemp_warn_n_out = 1'b0; // [R3]

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  reg [7:0] statusWord;

  always @* begin
    statusWord = 8'h00;
    statusWord[`ST_UV_BIT] = uvFault;
    statusWord[`ST_OTE_BIT] = oteLatch;
    statusWord[`ST_OLP_AB_BIT] = overload_fault[0];
    statusWord[`ST_OLP_CD_BIT] = overload_fault[1];
    statusWord[`ST_WARN_BIT] = overtemp_warn_n_oe & ~overtemp_warn_n_in;
    statusWord[`ST_LIM_AB_BIT] = |currentLimitActive[1:0];
    statusWord[`ST_LIM_CD_BIT] = |currentLimitActive[3:2];
    statusWord[`ST_SDPIN_BIT] = ~shutdown_flag_n_in;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      regRdData <= 8'h00;
    else if (clkEn) begin
      if (regRead && regAddr == `ADDR_CTRL)
        regRdData <= ctrl;
      else if (regRead && regAddr == `ADDR_STATUS)
        regRdData <= statusWord;
      else
        regRdData <= 8'h00;
    end
  end

endmodule // power_stage_fault_protection

// ### tb/power_stage_fault_protection_asserts.sv
// port assertions for the power stage fault protection block
module power_stage_fault_protection_asserts #(
  parameter OLP_CYCLES = 20
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] pwmIn,
  input wire pair_ab_reset_n,
  input wire pair_cd_reset_n,
  input wire [3:0] gate_drive_supply_ok,
  input wire common_supply_ok,
  input wire tempAboveWarn,
  input wire tempAboveError,
  input wire [3:0] overcurrent_high,
  input wire [3:0] overcurrent_low,
  input wire [3:0] highSideOn,
  input wire [3:0] lowSideOn,
  input wire [3:0] outputHiZ,
  input wire shutdown_flag_n_out,
  input wire shutdown_flag_n_oe,
  input wire overtemp_warn_n_oe
);
  // ----
  // helper counters
  // ----
  // pins go through synchronisers, so only long-settled levels are trusted
  reg [2:0] upCnt;
  reg [2:0] pinHigh;
  reg [7:0] ocCnt;
  wire live = upCnt == 3'h7;
  wire rsOk = pinHigh == 3'h7;
  wire supOk = &gate_drive_supply_ok && common_supply_ok;
  wire ocAb = |{overcurrent_high[1:0], overcurrent_low[1:0]};
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upCnt <= 3'h0;
      pinHigh <= 3'h0;
      ocCnt <= 8'h0;
    end else begin
      upCnt <= live ? upCnt : upCnt + 3'h1;
      pinHigh <= !(pair_ab_reset_n && pair_cd_reset_n) ? 3'h0 :
        rsOk ? pinHigh : pinHigh + 3'h1;
      ocCnt <= !(live && rsOk && supOk && !tempAboveError && ocAb) ? 8'h0 :
        (&ocCnt) ? ocCnt : ocCnt + 8'h1;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_uv_hiz: assert property (live && !supOk |=> outputHiZ == 4'hf)
    else $error("outputs not hi-z under undervoltage");
  a_fault_flag: assert property (live && rsOk && !supOk |=>
    shutdown_flag_n_oe) else $error("shutdown flag not pulled on fault");
  a_drain_low: assert property (shutdown_flag_n_out == 1'b0)
    else $error("open-drain data not low");
  a_warn_set: assert property (live && tempAboveWarn |=>
    overtemp_warn_n_oe) else $error("warning not pulled when hot");
  a_reset_frees: assert property (!pair_ab_reset_n [*4] |->
    !shutdown_flag_n_oe) else $error("shutdown flag pulled during reset");
  a_reset_hiz: assert property (!pair_cd_reset_n [*4] |->
    outputHiZ[3:2] == 2'b11) else $error("pair not hi-z during reset");
  a_limit_first: assert property (live && |{overcurrent_high,
    overcurrent_low} |=> !(|(highSideOn & $past(overcurrent_high)))
    && !(|(lowSideOn & $past(overcurrent_low))))
    else $error("tripped transistor left on");
  a_olp_persist: assert property (ocCnt == OLP_CYCLES + 6 |->
    outputHiZ[1:0] == 2'b11 && shutdown_flag_n_oe)
    else $error("persistent overcurrent did not shut pair down");
  a_ote_latch: assert property (live && rsOk &&
    $past(tempAboveError, 3) |-> outputHiZ == 4'hf && shutdown_flag_n_oe)
    else $error("overtemperature shutdown not held");
  a_pwm_follow: assert property (live && outputHiZ == 4'h0 &&
    $past(overcurrent_high) == 4'h0 && $past(overcurrent_low) == 4'h0 |->
    highSideOn == $past(pwmIn, 3) && lowSideOn == ~$past(pwmIn, 3))
    else $error("gates do not follow pwm inputs");
endmodule // power_stage_fault_protection_asserts

bind power_stage_fault_protection power_stage_fault_protection_asserts #(
  .OLP_CYCLES(OLP_CYCLES)
) u_power_stage_fault_protection_asserts (
  .clk, .resetn, .pwmIn, .pair_ab_reset_n, .pair_cd_reset_n,
  .gate_drive_supply_ok,
  .common_supply_ok, .tempAboveWarn, .tempAboveError, .overcurrent_high,
  .overcurrent_low, .highSideOn, .lowSideOn, .outputHiZ,
  .shutdown_flag_n_out, .shutdown_flag_n_oe, .overtemp_warn_n_oe
);

// ### tb/pwm_controller_model.sv
// model of the pwm modulator and system controller at the far side
module pwm_controller_model #(
  parameter FRAME = 260
) (
  input wire logic clk,
  input wire logic [1:0] holdReset,
  input wire logic sdOe,
  input wire logic warnOe,
  output logic [3:0] pwm,
  output logic pairAbResetN,
  output logic pairCdResetN,
  output wire logic sdLevel,
  output wire logic warnLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // behaviour
  // ----
  // index capped so every frame keeps a low stretch well over 5 cycles
  localparam HIGH = FRAME * 961 / 1000;
  int phase = 0;
  assign sdLevel = !sdOe;
  assign warnLevel = !warnOe;
  initial begin
    pwm = 4'h0;
    pairAbResetN = 1'b0;
    pairCdResetN = 1'b0;
  end
  always @(posedge clk) begin
    phase <= (phase == FRAME - 1) ? 0 : phase + 1;
    for (int i = 0; i < 4; i++)
      pwm[i] <= ((phase + 65 * i) % FRAME) < HIGH;
    pairAbResetN <= !holdReset[0];
    pairCdResetN <= !holdReset[1];
  end
endmodule // pwm_controller_model

// ### tb/power_stage_fault_protection_test.sv
// self-checking bench of the power stage fault protection block
module power_stage_fault_protection_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // wiring
  // ----
  localparam int OVERLOAD_FAULT = 20;
  localparam int CLEAR_WAIT = 50;
  logic clk;
  logic resetn = 0;
  logic [1:0] holdReset = 2'h3;
  logic [3:0] gdOk = 4'hf;
  logic comOk = 1;
  logic tWarn = 0;
  logic tErr = 0;
  logic [3:0] ocH = 0;
  logic [3:0] ocL = 0;
  logic [3:0] regAddr = 0;
  logic [7:0] regWrData = 0;
  logic regWrite = 0;
  logic regRead = 0;
  logic rdLag = 0;
  logic [7:0] regRdData, wd;
  logic [3:0] highSideOn, lowSideOn, outputHiZ, weakPulldownEn;
  logic [3:0] currentLimitActive, pwm;
  logic abN, cdN, sdOe, warnOe, sdLevel, warnLevel;
  logic [7:0] expQ[$];
  int seed = 90;
  int n_fail = 0;
  int total_checks = 0;
  power_stage_fault_protection #(.OLP_CYCLES(OVERLOAD_FAULT))
  u_power_stage_fault_protection (
    .clk, .resetn, .clkEn(1'b1), .pwmIn(pwm), .pair_ab_reset_n(abN),
    .pair_cd_reset_n(cdN), .gate_drive_supply_ok(gdOk),
    .common_supply_ok(comOk), .tempAboveWarn(tWarn), .tempAboveError(tErr),
    .overcurrent_high(ocH), .overcurrent_low(ocL), .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .highSideOn, .lowSideOn, .outputHiZ,
    .weakPulldownEn, .currentLimitActive, .shutdown_flag_n_in(sdLevel),
    .shutdown_flag_n_out(), .shutdown_flag_n_oe(sdOe),
    .overtemp_warn_n_in(warnLevel), .overtemp_warn_n_out(),
    .overtemp_warn_n_oe(warnOe));
  pwm_controller_model u_pwm_controller_model (
    .clk, .holdReset, .sdOe, .warnOe, .pwm, .pairAbResetN(abN),
    .pairCdResetN(cdN), .sdLevel, .warnLevel);
  // ----
  // tasks
  // ----
  task ck(input string what, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task pins(input logic [3:0] z, input logic sd, input logic wn);
    ck("outputHiZ", {4'h0, z}, {4'h0, outputHiZ});
    ck("sdLevel", {7'h0, sd}, {7'h0, sdLevel});
    ck("warnLevel", {7'h0, wn}, {7'h0, warnLevel});
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  task pulse(input logic [1:0] m);
    @(posedge clk);
    holdReset <= m;
    w(6);
    ck("sdForced", 8'h01, {7'h0, sdLevel});
    @(posedge clk);
    holdReset <= 2'h0;
    w(8);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----
  // processes
  // ----
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rdLag)
      ck("regRdData", expQ.pop_front(), regRdData);
    rdLag <= regRead;
  end
  // whole run is under 1000 cycles; the limit leaves ample slack
  initial begin
    #50000;
    n_fail++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    w(6);
    pins(4'hf, 1, 1);
    ck("pulldown", 8'h0f, {4'h0, weakPulldownEn});
    @(posedge clk);
    holdReset <= 2'h0;
    w(8);
    pins(4'h0, 1, 1);
    rd(4'h1, 8'h00);
    rd(4'h7, 8'h00);
    wd = 8'($random(seed)) & 8'h03;
    wr(4'h0, wd);
    rd(4'h0, wd);
    wr(4'h1, 8'hff);
    wr(4'h7, 8'hff);
    rd(4'h0, wd);
    wr(4'h0, 8'h01);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      gdOk <= (i < 4) ? ~(4'h1 << i) : 4'hf;
      comOk <= (i < 4);
      w(2);
      pins(4'hf, 0, 1);
      rd(4'h1, 8'h81);
      @(posedge clk);
      gdOk <= 4'hf;
      comOk <= 1'b1;
      w(2);
      pins(4'h0, 1, 1);
    end
    @(posedge clk);
    tWarn <= 1'b1;
    w(2);
    pins(4'h0, 1, 0);
    @(posedge clk);
    tWarn <= 1'b0;
    w(2);
    pins(4'h0, 1, 1);
    @(posedge clk);
    tWarn <= 1'b1;
    tErr <= 1'b1;
    w(2);
    pins(4'hf, 0, 0);
    @(posedge clk);
    tWarn <= 1'b0;
    tErr <= 1'b0;
    w(4);
    pins(4'hf, 0, 0);
    pulse(2'h1);
    pins(4'hf, 0, 0);
    pulse(2'h3);
    pins(4'h0, 1, 1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      {ocL, ocH} <= 8'h01 << i;
      w(2);
      ck("limit", 8'h01 << (i % 4), {4'h0, currentLimitActive});
      ck("gateOff", 8'h00, {lowSideOn, highSideOn} & (8'h01 << i));
      ck("noTrip", 8'h00, {4'h0, outputHiZ});
      @(posedge clk);
      {ocL, ocH} <= 8'h00;
      w(3);
    end
    @(posedge clk);
    ocH <= 4'h1;
    w(OVERLOAD_FAULT - 4);
    pins(4'h0, 1, 1);
    w(10);
    pins(4'h3, 0, 1);
    @(posedge clk);
    ocH <= 4'h0;
    w(CLEAR_WAIT);
    pins(4'h3, 0, 1);
    pulse(2'h2);
    pins(4'h0, 1, 1);
    @(posedge clk);
    holdReset <= 2'h3;
    w(4);
    @(posedge clk);
    comOk <= 1'b0;
    w(4);
    end_sim;
  end
endmodule // power_stage_fault_protection_test
